// *** verilog/isacfg_consts.svh ***
// Constants for the bus window, register offsets, resets and timing.
`ifndef ISACFG_CONSTS_SVH
`define ISACFG_CONSTS_SVH

// Host bus widths.
`define ISACFG_ADDR_W 10
`define ISACFG_DATA_W 16
`define ISACFG_SW_W 5
`define ISACFG_IRQ_N 9

// Window decode: bit nine must be one, four low bits are the offset.
`define ISACFG_A9_POS 9
`define ISACFG_SW_HI 8
`define ISACFG_SW_LO 4
`define ISACFG_OFF_W 4
`define ISACFG_RANGE_LO 10'h200
`define ISACFG_RANGE_HI 10'h3ff
`define ISACFG_SW_DEFAULT 5'h02
`define ISACFG_BASE_DEFAULT 10'h220

// Register offsets inside the sixteen-port window.
`define ISACFG_OFF_CNT0 4'h0
`define ISACFG_OFF_CNT1 4'h1
`define ISACFG_OFF_CNT2 4'h2
`define ISACFG_OFF_MODE 4'h8
`define ISACFG_OFF_SWTRIG 4'h9
`define ISACFG_OFF_STRAP 4'ha

// Reset values.
`define ISACFG_RELOAD_RST 16'h0000
`define ISACFG_CNT_RST 16'h0000

// Timing: system clock and on-board oscillator rates in hertz.
`define ISACFG_CLK_HZ 50000000
`define ISACFG_OSC_HZ 2000000
`define ISACFG_OSC_DIV (`ISACFG_CLK_HZ / `ISACFG_OSC_HZ)
`define ISACFG_DIV_W 5

`endif

// *** verilog/isacfg_pkg.sv ***
// Types shared by the card decode and configuration block.
package isacfg_pkg;
    // Internal conversion trigger source chosen by the mode register.
    typedef enum logic [0:0] {
        ISACFG_TRIG_SOFTWARE = 1'b0,
        ISACFG_TRIG_PACER = 1'b1
    } isacfg_trig_t;

    // Board-level straps for triggers and the general counter clock.
    typedef enum logic [0:0] {
        ISACFG_SRC_INTERNAL = 1'b0,
        ISACFG_SRC_EXTERNAL = 1'b1
    } isacfg_src_t;
endpackage

// *** verilog/isacfg_decode.sv ***
// Address decoder for the sixteen-port host I/O window.
`timescale 1ns/1ps
`include "isacfg_consts.svh"
module isacfg_decode (
    input wire logic [`ISACFG_ADDR_W-1:0] addr,
    input wire logic [`ISACFG_SW_W-1:0] base_address_switch_bank,
    output logic hit,
    output logic [`ISACFG_OFF_W-1:0] offset
);
    import isacfg_pkg::*;

    // An open switch matches a one and a closed switch matches a zero.
    wire a9_set = addr[`ISACFG_A9_POS];
    wire [`ISACFG_SW_W-1:0] upper_bits = addr[`ISACFG_SW_HI:`ISACFG_SW_LO];
    wire base_match = (upper_bits == base_address_switch_bank);

    // The low four bits never take part in the match.
    assign hit = a9_set && base_match;
    assign offset = addr[`ISACFG_OFF_W-1:0];
endmodule

// *** verilog/isacfg_counter.sv ***
// One sixteen-bit programmable down counter with reload.
`timescale 1ns/1ps
`include "isacfg_consts.svh"
module isacfg_counter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic load,
    input wire logic [`ISACFG_DATA_W-1:0] load_val,
    output logic [`ISACFG_DATA_W-1:0] count,
    output logic tc
);
    import isacfg_pkg::*;

    logic [`ISACFG_DATA_W-1:0] count_r;
    logic [`ISACFG_DATA_W-1:0] count_nxt;
    logic tc_r;

    // A reload of zero counts the full 65536 ticks by wrapping.
    wire at_one = (count_r == `ISACFG_DATA_W'(1));
    wire terminal = tick && at_one && !load;
    assign count_nxt = load ? load_val :
                       terminal ? load_val :
                       tick ? count_r - `ISACFG_DATA_W'(1) : count_r;

    // The count and its terminal pulse are both held in flip-flops.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= `ISACFG_CNT_RST;
            tc_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tc_r <= terminal;
        end
    end

    assign count = count_r;
    assign tc = tc_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_counter_reload: assert property (
        tick && at_one && !load |=> tc && count_r == $past(load_val))
        else $error("Counter did not reload at terminal count.");
    a_counter_step: assert property (
        tick && !load && !at_one |=>
        count_r == $past(count_r) - `ISACFG_DATA_W'(1) && !tc)
        else $error("Counter did not step down by one.");
endmodule

// *** verilog/isacfg_top.sv ***
// Host window decode, strap routing and counter clock tree of the card.
`timescale 1ns/1ps
`include "isacfg_consts.svh"

module isacfg_top (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [`ISACFG_ADDR_W-1:0] BUS_ADDR,
    input wire logic [`ISACFG_DATA_W-1:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    output logic [`ISACFG_DATA_W-1:0] BUS_RDATA,
    output logic WINDOW_HIT,
    input wire logic [`ISACFG_SW_W-1:0] BASE_ADDRESS_SWITCH_BANK,
    input wire isacfg_pkg::isacfg_src_t TRIGGER_SOURCE_STRAP,
    input wire isacfg_pkg::isacfg_src_t COUNTER_CLOCK_STRAP,
    input wire logic DMA_CHANNEL_STRAP_A,
    input wire logic DMA_CHANNEL_STRAP_B,
    input wire logic [`ISACFG_IRQ_N-1:0] INTERRUPT_LINE_STRAP,
    input wire logic EXT_CLOCK_IN,
    input wire logic EXT_TRIGGER_IN,
    input wire logic DMA_REQUEST,
    input wire logic IRQ_REQUEST,
    output logic CONV_TRIGGER,
    output logic PACER_OUT,
    output logic COUNTER0_OUT,
    output logic DRQ_CH1,
    output logic DRQ_CH3,
    output logic [`ISACFG_IRQ_N-1:0] IRQ_LINES
);
    import isacfg_pkg::*;

    localparam int NCNT = 3;

    // Decoder results.
    logic hit;
    logic [`ISACFG_OFF_W-1:0] offset;

    // Registers and their next values.
    logic [`ISACFG_DATA_W-1:0] reload_r [NCNT];
    isacfg_trig_t mode_r;
    isacfg_trig_t mode_nxt;
    logic [`ISACFG_DATA_W-1:0] rdata_r;
    logic [`ISACFG_DATA_W-1:0] rdata_nxt;
    logic [`ISACFG_DIV_W-1:0] div_r;
    logic [`ISACFG_DIV_W-1:0] div_nxt;
    logic ext_clk_s1_r;
    logic ext_clk_s2_r;
    logic ext_clk_s3_r;
    logic ext_trg_s1_r;
    logic ext_trg_s2_r;
    logic ext_trg_s3_r;
    logic conv_trig_r;
    logic conv_trig_nxt;
    logic drq1_r;
    logic drq3_r;
    logic [`ISACFG_IRQ_N-1:0] irq_r;

    // Counter wiring, indexed by counter number.
    logic [NCNT-1:0] cnt_tick;
    logic [NCNT-1:0] cnt_load;
    logic [NCNT-1:0] cnt_tc;
    logic [`ISACFG_DATA_W-1:0] cnt_val [NCNT];

    // Window decode; switch bank is static and used as is.
    isacfg_decode u_decode (
        .addr(BUS_ADDR),
        .base_address_switch_bank(BASE_ADDRESS_SWITCH_BANK),
        .hit(hit),
        .offset(offset)
    );

    assign WINDOW_HIT = hit;

    // Write and read strobes qualified by the window.
    wire wr_hit = BUS_WR && hit;
    wire rd_hit = BUS_RD && hit;
    wire wr_mode = wr_hit && (offset == `ISACFG_OFF_MODE);
    wire sw_trig = wr_hit && (offset == `ISACFG_OFF_SWTRIG);

    // The 2MHz time base is a tick every twenty-five system clocks.
    wire osc_tick = (div_r == `ISACFG_DIV_W'(`ISACFG_OSC_DIV - 1));
    assign div_nxt = osc_tick ? '0 : div_r + `ISACFG_DIV_W'(1);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    // Two-flop synchronisers and one more stage for edge detection.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ext_clk_s1_r <= 1'b0;
            ext_clk_s2_r <= 1'b0;
            ext_clk_s3_r <= 1'b0;
            ext_trg_s1_r <= 1'b0;
            ext_trg_s2_r <= 1'b0;
            ext_trg_s3_r <= 1'b0;
        end else begin
            ext_clk_s1_r <= EXT_CLOCK_IN;
            ext_clk_s2_r <= ext_clk_s1_r;
            ext_clk_s3_r <= ext_clk_s2_r;
            ext_trg_s1_r <= EXT_TRIGGER_IN;
            ext_trg_s2_r <= ext_trg_s1_r;
            ext_trg_s3_r <= ext_trg_s2_r;
        end
    end

    wire ext_clk_rise = ext_clk_s2_r && !ext_clk_s3_r;
    wire ext_trg_rise = ext_trg_s2_r && !ext_trg_s3_r;

    // Clock tree: counter two on the oscillator, one on two, zero strapped.
    wire c0_ext = (COUNTER_CLOCK_STRAP == ISACFG_SRC_EXTERNAL);
    assign cnt_tick[0] = c0_ext ? ext_clk_rise : osc_tick;
    assign cnt_tick[1] = cnt_tc[2];
    assign cnt_tick[2] = osc_tick;

    // One reload register and one counter per channel.
    genvar gi;
    generate
        for (gi = 0; gi < NCNT; gi++) begin : g_cnt
            assign cnt_load[gi] =
                wr_hit && (offset == `ISACFG_OFF_W'(gi));

            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    reload_r[gi] <= `ISACFG_RELOAD_RST;
                end else if (cnt_load[gi]) begin
                    reload_r[gi] <= BUS_WDATA;
                end
            end

            isacfg_counter u_cnt (
                .clk(CLK),
                .resetn(RESETN),
                .tick(cnt_tick[gi]),
                .load(cnt_load[gi]),
                .load_val(cnt_load[gi] ? BUS_WDATA : reload_r[gi]),
                .count(cnt_val[gi]),
                .tc(cnt_tc[gi])
            );
        end
    endgenerate

    assign PACER_OUT = cnt_tc[1];
    assign COUNTER0_OUT = cnt_tc[0];

    // Mode register selects the internal trigger source.
    assign mode_nxt = wr_mode ? isacfg_trig_t'(BUS_WDATA[0]) : mode_r;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_r <= ISACFG_TRIG_SOFTWARE;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Trigger selection: strap first, then the mode register.
    wire trg_ext = (TRIGGER_SOURCE_STRAP == ISACFG_SRC_EXTERNAL);
    wire int_trig = (mode_r == ISACFG_TRIG_PACER) ? cnt_tc[1] : sw_trig;
    assign conv_trig_nxt = trg_ext ? ext_trg_rise : int_trig;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            conv_trig_r <= 1'b0;
        end else begin
            conv_trig_r <= conv_trig_nxt;
        end
    end

    assign CONV_TRIGGER = conv_trig_r;

    // DMA routing; channel one wins if both straps are fitted.
    wire dma_ch1 = DMA_CHANNEL_STRAP_A;
    wire dma_ch3 = DMA_CHANNEL_STRAP_B && !DMA_CHANNEL_STRAP_A;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            drq1_r <= 1'b0;
            drq3_r <= 1'b0;
        end else begin
            drq1_r <= DMA_REQUEST && dma_ch1;
            drq3_r <= DMA_REQUEST && dma_ch3;
        end
    end

    assign DRQ_CH1 = drq1_r;
    assign DRQ_CH3 = drq3_r;

    // Each interrupt line is driven only while its strap is fitted.
    generate
        for (gi = 0; gi < `ISACFG_IRQ_N; gi++) begin : g_irq
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    irq_r[gi] <= 1'b0;
                end else begin
                    irq_r[gi] <= IRQ_REQUEST
                        && INTERRUPT_LINE_STRAP[gi];
                end
            end
        end
    endgenerate

    assign IRQ_LINES = irq_r;

    // Strap status word shows the switch bank and the DMA, trigger and clock straps to software.
    wire [`ISACFG_DATA_W-1:0] strap_word = {
        7'h00, COUNTER_CLOCK_STRAP, TRIGGER_SOURCE_STRAP,
        DMA_CHANNEL_STRAP_B, DMA_CHANNEL_STRAP_A,
        BASE_ADDRESS_SWITCH_BANK
    };

    // Read selection; unmapped offsets and misses return zero.
    wire sel_cnt = (offset < `ISACFG_OFF_W'(NCNT));
    wire [`ISACFG_DATA_W-1:0] cnt_word = sel_cnt ?
        cnt_val[offset[1:0]] : '0;
    wire [`ISACFG_DATA_W-1:0] mode_word =
        {{(`ISACFG_DATA_W-1){1'b0}}, mode_r};
    wire [`ISACFG_DATA_W-1:0] sel_word =
        (offset == `ISACFG_OFF_MODE) ? mode_word :
        (offset == `ISACFG_OFF_STRAP) ? strap_word : cnt_word;
    assign rdata_nxt = rd_hit ? sel_word : '0;

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign BUS_RDATA = rdata_r;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_a9_required: assert property (
        !BUS_ADDR[`ISACFG_A9_POS] |-> !WINDOW_HIT)
        else $error("Window hit with address bit nine low.");

    a_window_span: assert property (
        WINDOW_HIT |-> BUS_ADDR[`ISACFG_SW_HI:`ISACFG_SW_LO]
            == BASE_ADDRESS_SWITCH_BANK)
        else $error("Window hit outside the sixteen-port span.");

    a_range_bound: assert property (
        WINDOW_HIT |-> BUS_ADDR >= `ISACFG_RANGE_LO
            && BUS_ADDR <= `ISACFG_RANGE_HI)
        else $error("Window hit outside the permitted range.");

    a_switch_polarity: assert property (
        BUS_ADDR[`ISACFG_A9_POS] && BUS_ADDR[`ISACFG_SW_HI:`ISACFG_SW_LO]
            == BASE_ADDRESS_SWITCH_BANK |-> WINDOW_HIT)
        else $error("Matching address was not decoded.");

    a_default_base: assert property (
        BASE_ADDRESS_SWITCH_BANK == `ISACFG_SW_DEFAULT
            && BUS_ADDR == `ISACFG_BASE_DEFAULT |-> WINDOW_HIT)
        else $error("Factory base was not decoded.");

    a_miss_reads_zero: assert property (
        BUS_RD && !WINDOW_HIT |=> BUS_RDATA == '0)
        else $error("Read outside the window returned data.");

    a_osc_spacing: assert property (
        osc_tick |=> !osc_tick [*8])
        else $error("Oscillator ticks came too close.");

    a_cnt2_source: assert property (
        $changed(cnt_val[2]) |-> $past(osc_tick || cnt_load[2]))
        else $error("Counter two moved without an oscillator tick.");

    a_cnt1_cascade: assert property (
        $changed(cnt_val[1]) |-> $past(cnt_tc[2] || cnt_load[1]))
        else $error("Counter one moved without counter two output.");

    a_cnt0_source: assert property (
        $changed(cnt_val[0]) |-> $past(cnt_load[0]
            || (c0_ext ? ext_clk_rise : osc_tick)))
        else $error("Counter zero moved without its strapped clock.");

    a_ext_trigger: assert property (
        trg_ext && ext_trg_rise |=> CONV_TRIGGER)
        else $error("External trigger edge was lost.");

    a_ext_blocks_int: assert property (
        trg_ext && !ext_trg_rise |=> !CONV_TRIGGER)
        else $error("Internal trigger passed while strapped external.");

    a_soft_trigger: assert property (
        !trg_ext && mode_r == ISACFG_TRIG_SOFTWARE && sw_trig
            |=> CONV_TRIGGER)
        else $error("Software trigger did not fire.");

    a_pacer_trigger: assert property (
        !trg_ext && mode_r == ISACFG_TRIG_PACER |=>
            CONV_TRIGGER == $past(PACER_OUT))
        else $error("Pacer trigger did not follow counter one.");

    a_dma_route: assert property (
        DMA_REQUEST && !DMA_CHANNEL_STRAP_A && DMA_CHANNEL_STRAP_B
            |=> DRQ_CH3 && !DRQ_CH1)
        else $error("DMA request not routed to channel three.");

    a_dma_ch1_route: assert property (
        DMA_REQUEST && DMA_CHANNEL_STRAP_A |=> DRQ_CH1 && !DRQ_CH3)
        else $error("DMA request not routed to channel one.");

    a_rdata_clear: assert property (
        !rd_hit |=> BUS_RDATA == '0)
        else $error("Read data stood without a window read.");

    a_irq_route: assert property (
        ##1 IRQ_LINES == $past(INTERRUPT_LINE_STRAP
            & {`ISACFG_IRQ_N{IRQ_REQUEST}}))
        else $error("Interrupt not routed to the strapped line.");

    c_pacer_fire: cover property (
        !trg_ext && mode_r == ISACFG_TRIG_PACER ##1 CONV_TRIGGER);
    c_ext_fire: cover property (trg_ext && ext_trg_rise ##1 CONV_TRIGGER);
    c_ext_count: cover property (c0_ext && ext_clk_rise);
    c_window_read: cover property (rd_hit ##1 BUS_RDATA != '0);
    c_soft_fire: cover property (sw_trig && !trg_ext ##1 CONV_TRIGGER);
endmodule

// *** test/isacfg_host_model.sv ***
// Host processor model that issues I/O cycles on the card's register port.
`timescale 1ns/1ps
`include "isacfg_consts.svh"
module isacfg_host_model (
    input wire logic clk,
    input wire logic [`ISACFG_DATA_W-1:0] rdata,
    output logic [`ISACFG_ADDR_W-1:0] addr,
    output logic [`ISACFG_DATA_W-1:0] wdata,
    output logic wr,
    output logic rd
);
    // The bus starts idle with both strobes low.
    initial begin
        addr = 10'h000;
        wdata = 16'h0000;
        wr = 1'h0;
        rd = 1'h0;
    end

    // Drive an address only; used to probe the combinational window decode.
    task automatic put_addr(input logic [`ISACFG_ADDR_W-1:0] a);
        addr <= a;
    endtask

    // One write cycle; released lines are inverted so nothing looks held.
    task automatic wr_io(input logic [`ISACFG_ADDR_W-1:0] a,
                         input logic [`ISACFG_DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        addr <= ~a;
        wdata <= ~d;
    endtask

    // One read cycle; data are taken in the single cycle where they stand.
    task automatic rd_io(input logic [`ISACFG_ADDR_W-1:0] a,
                         output logic [`ISACFG_DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the card's window decode and strap routing.
`timescale 1ns/1ps
`include "isacfg_consts.svh"
module testbench;
    import isacfg_pkg::*;
    typedef struct packed {
        logic [`ISACFG_SW_W-1:0] sw;
        logic [`ISACFG_ADDR_W-1:0] a;
        logic hit;
    } isacfg_row_t;
    logic clk = 1'h0;
    logic resetn, bus_wr, bus_rd, window_hit, dma_a, dma_b;
    logic ext_clk, ext_trig, dma_req, irq_req;
    logic conv_trig, pacer, c0_out, drq1, drq3;
    logic [`ISACFG_ADDR_W-1:0] bus_addr;
    logic [`ISACFG_DATA_W-1:0] bus_wdata, bus_rdata, rd_val;
    logic [`ISACFG_SW_W-1:0] sw;
    logic [`ISACFG_IRQ_N-1:0] irq_strap, irq_lines;
    isacfg_src_t trig_strap, clk_strap;
    wire [2:0] pulses = {conv_trig, pacer, c0_out};
    int fails = 0, num_checks = 0, cycles = 0, conv_n = 0, c0_n = 0, snap;
    isacfg_row_t rows [13] = '{
        '{5'h02, 10'h220, 1'h1}, '{5'h02, 10'h22f, 1'h1},
        '{5'h02, 10'h21f, 1'h0}, '{5'h02, 10'h230, 1'h0},
        '{5'h02, 10'h020, 1'h0}, '{5'h00, 10'h200, 1'h1},
        '{5'h00, 10'h000, 1'h0}, '{5'h1f, 10'h3ff, 1'h1},
        '{5'h1f, 10'h3f0, 1'h1}, '{5'h1f, 10'h1f0, 1'h0},
        '{5'h10, 10'h300, 1'h1}, '{5'h01, 10'h210, 1'h1},
        '{5'h01, 10'h200, 1'h0}};

    // The 50 MHz system clock.
    always #10 clk = ~clk;

    // Cycle ceiling cuts a hang short; pulse counters watch the outputs.
    always @(posedge clk) begin
        cycles++;
        if (conv_trig === 1'h1) conv_n++;
        if (c0_out === 1'h1) c0_n++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    isacfg_top isacfg_top_inst (.CLK(clk), .RESETN(resetn),
        .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr),
        .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .WINDOW_HIT(window_hit),
        .BASE_ADDRESS_SWITCH_BANK(sw), .TRIGGER_SOURCE_STRAP(trig_strap),
        .COUNTER_CLOCK_STRAP(clk_strap), .DMA_CHANNEL_STRAP_A(dma_a),
        .DMA_CHANNEL_STRAP_B(dma_b), .INTERRUPT_LINE_STRAP(irq_strap),
        .EXT_CLOCK_IN(ext_clk), .EXT_TRIGGER_IN(ext_trig),
        .DMA_REQUEST(dma_req), .IRQ_REQUEST(irq_req),
        .CONV_TRIGGER(conv_trig), .PACER_OUT(pacer),
        .COUNTER0_OUT(c0_out), .DRQ_CH1(drq1), .DRQ_CH3(drq3),
        .IRQ_LINES(irq_lines));

    isacfg_host_model isacfg_host_model_inst (.clk(clk),
        .rdata(bus_rdata), .addr(bus_addr), .wdata(bus_wdata),
        .wr(bus_wr), .rd(bus_rd));

    // Compare a seen value with the expected one and count the result.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: %s saw %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    // Address of a register offset in the factory window.
    function automatic logic [9:0] adr(input logic [3:0] off);
        return `ISACFG_BASE_DEFAULT | {6'h00, off};
    endfunction

    // Cycles between two successive pulses on the chosen output.
    task automatic period(input int sel, input logic [15:0] exp,
                          input string what);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (pulses[sel] !== 1'h1 && n < 400);
        end
        check(16'(n), exp, what);
    endtask

    // Print the counts and the verdict, then end the run.
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence: table of decode cases, then hand-written cases.
    initial begin
        resetn = 1'h0;
        {dma_a, dma_b, ext_clk, ext_trig, dma_req, irq_req} = 6'h20;
        sw = `ISACFG_SW_DEFAULT;
        irq_strap = 9'h002;
        trig_strap = ISACFG_SRC_INTERNAL;
        clk_strap = ISACFG_SRC_INTERNAL;
        repeat (3) @(posedge clk);
        #1;
        check({11'h000, pulses, drq1, drq3}, 16'h0000, "reset outs");
        check(16'(irq_lines) | bus_rdata, 16'h0000, "bus in reset");
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        $display("reset done");
        foreach (rows[i]) begin
            @(posedge clk);
            sw <= rows[i].sw;
            isacfg_host_model_inst.put_addr(rows[i].a);
            #1;
            check(16'(window_hit), 16'(rows[i].hit), "hit");
        end
        // Switch bits match but address bit nine is low: no hit.
        @(posedge clk);
        isacfg_host_model_inst.put_addr(10'h010);
        #1;
        check(16'(window_hit), 16'h0000, "no A9 hit");
        sw <= `ISACFG_SW_DEFAULT;
        $display("decode table done");
        // Out-of-window and unmapped reads give zero; the strap word reads.
        isacfg_host_model_inst.rd_io(10'h120, rd_val);
        check(rd_val, 16'h0000, "outside read");
        isacfg_host_model_inst.rd_io(adr(4'h5), rd_val);
        check(rd_val, 16'h0000, "unmapped read");
        isacfg_host_model_inst.rd_io(adr(`ISACFG_OFF_STRAP), rd_val);
        check(rd_val, 16'h0022, "strap word");
        // Full sixteen-bit reload reads back while counter one is idle.
        isacfg_host_model_inst.wr_io(adr(`ISACFG_OFF_CNT2), 16'hffff);
        isacfg_host_model_inst.wr_io(adr(`ISACFG_OFF_CNT1), 16'h1234);
        isacfg_host_model_inst.rd_io(adr(`ISACFG_OFF_CNT1), rd_val);
        check(rd_val, 16'h1234, "count1 width");
        // Software trigger gives one pulse the cycle after the write.
        isacfg_host_model_inst.wr_io(adr(`ISACFG_OFF_SWTRIG), 16'h0000);
        #1;
        check(16'(conv_trig), 16'h0001, "sw trigger");
        @(posedge clk);
        #1;
        check(16'(conv_trig), 16'h0000, "sw trigger end");
        // External strap ignores software but follows the trigger pin.
        trig_strap <= ISACFG_SRC_EXTERNAL;
        snap = conv_n;
        isacfg_host_model_inst.wr_io(adr(`ISACFG_OFF_SWTRIG), 16'h0000);
        repeat (6) @(posedge clk);
        check(16'(conv_n - snap), 16'h0000, "sw ignored");
        ext_trig <= 1'h1;
        repeat (8) @(posedge clk);
        check(16'(conv_n - snap), 16'h0001, "ext trigger");
        ext_trig <= 1'h0;
        trig_strap <= ISACFG_SRC_INTERNAL;
        $display("trigger done");
        // Pacer chain: counter two ticks at 2 MHz, counter one follows it.
        isacfg_host_model_inst.wr_io(adr(`ISACFG_OFF_CNT2), 16'h0002);
        isacfg_host_model_inst.wr_io(adr(`ISACFG_OFF_CNT1), 16'h0002);
        isacfg_host_model_inst.wr_io(adr(`ISACFG_OFF_MODE), 16'h0001);
        isacfg_host_model_inst.rd_io(adr(`ISACFG_OFF_MODE), rd_val);
        check(rd_val, 16'h0001, "mode");
        period(1, 16'h0064, "pacer period");
        period(2, 16'h0064, "pacer trigger");
        isacfg_host_model_inst.wr_io(adr(`ISACFG_OFF_CNT0), 16'h0003);
        period(0, 16'h004b, "counter0 internal");
        // External clock: three pin edges make one terminal count.
        clk_strap <= ISACFG_SRC_EXTERNAL;
        isacfg_host_model_inst.wr_io(adr(`ISACFG_OFF_CNT0), 16'h0003);
        snap = c0_n;
        for (int k = 0; k < 3; k++) begin
            if (k == 2)
                check(16'(c0_n - snap), 16'h0000, "ext two edges");
            repeat (10) @(posedge clk);
            ext_clk <= 1'h1;
            repeat (10) @(posedge clk);
            ext_clk <= 1'h0;
        end
        check(16'(c0_n - snap), 16'h0001, "ext three edges");
        $display("counters done");
        // DMA channel routing for each strap setting; interrupt routing on lines 1, 3, 5 and 7.
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {dma_a, dma_b} <= 2'(i);
            irq_strap <= 9'h001 << (2 * i + 1);
            dma_req <= 1'h1;
            irq_req <= 1'h1;
            @(posedge clk);
            @(posedge clk);
            #1;
            check({drq1, drq3}, {i[1], i[0] & ~i[1]}, "drq");
            check(16'(irq_lines), 16'h002 << (2 * i), "irq");
        end
        dma_req <= 1'h0;
        irq_req <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
        check(16'(irq_lines) | {drq1, drq3}, 16'h0000, "req low");
        $display("routing done");
        // A second reset in mid-run clears the mode back to software.
        resetn <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
        check({13'h0000, pulses}, 16'h0000, "mid reset");
        resetn <= 1'h1;
        isacfg_host_model_inst.rd_io(adr(`ISACFG_OFF_MODE), rd_val);
        check(rd_val, 16'h0000, "mode after reset");
        $display("second reset done");
        stop_test();
    end
endmodule
